// ===== include/obcd_pkg.sv
// Purpose: constants and types of the option byte config decoder
// Assumes: 125 MHz system clock, byte-wide flash read port
// Notes:   register byte address is four times the register index
package obcd_pkg;

  // ==========================================================
  // flash option area
  localparam int          FLASH_AW     = 17;
  localparam logic [16:0] OPT_BASE_PRI = 17'h000c0;
  localparam logic [16:0] OPT_BASE_ALT = 17'h010c0;
  localparam int          OPT_BYTES    = 4;
  localparam logic [7:0]  OPT_BYTE_RST = 8'hff;

  // ==========================================================
  // register indexes (byte address = index * 4)
  localparam int         BUS_AW        = 10;
  localparam logic [7:0] IDX_WDT_OPT   = 8'hc0;
  localparam logic [7:0] IDX_OSC_LV    = 8'hc1;
  localparam logic [7:0] IDX_RSVD      = 8'hc2;
  localparam logic [7:0] IDX_DBG       = 8'hc3;
  localparam logic [7:0] IDX_STATUS    = 8'h10;
  localparam logic [7:0] IDX_LV_CTRL   = 8'h11;
  localparam logic [7:0] IDX_FOSC_CTRL = 8'h12;

  // ==========================================================
  // field positions
  localparam int WDT_STBY_BIT  = 0;
  localparam int WDT_OVF_LSB   = 1;
  localparam int WDT_EN_BIT    = 4;
  localparam int WIN_LO_BIT    = 5;
  localparam int WIN_HI_BIT    = 6;
  localparam int WDT_IRQ_BIT   = 7;
  localparam int LV_OFF_BIT    = 0;
  localparam int FREQ_LO_BIT   = 1;
  localparam int FREQ_HI_BIT   = 2;
  localparam int DBG_KEEP_BIT  = 0;
  localparam int DBG_EN_BIT    = 7;
  localparam int DBG_OVW_LSB   = 1;
  localparam int DBG_OVW_MSB   = 3;
  localparam int LV_ON_BIT     = 0;
  localparam int FOSC_ON_BIT   = 0;

  // status register bits
  localparam int ST_VALID_BIT  = 0;
  localparam int ST_CPU_BIT    = 1;
  localparam int ST_SWAP_BIT   = 2;
  localparam int ST_UNSET_BIT  = 3;
  localparam int ST_WIN_ERR    = 4;
  localparam int ST_FREQ_ERR   = 5;
  localparam int ST_DBG_ERR    = 6;
  localparam int ST_FMT_ERR    = 7;

  // ==========================================================
  // codes and fixed patterns
  localparam logic [1:0] WIN_50     = 2'h1;
  localparam logic [1:0] WIN_75     = 2'h2;
  localparam logic [1:0] WIN_100    = 2'h3;
  localparam logic [6:0] PCT_0      = 7'h00;
  localparam logic [6:0] PCT_50     = 7'h32;
  localparam logic [6:0] PCT_75     = 7'h4b;
  localparam logic [6:0] PCT_100    = 7'h64;
  localparam logic [1:0] FREQ_8_20  = 2'h1;
  localparam logic [1:0] FREQ_1     = 2'h2;
  localparam logic [1:0] DBG_OFF    = 2'h0;
  localparam logic [1:0] DBG_ERASE  = 2'h2;
  localparam logic [1:0] DBG_KEEP   = 2'h3;
  localparam logic [4:0] OSC_HI_ONES = 5'h1f;
  localparam logic [7:0] RSVD_VAL    = 8'hff;
  localparam logic [5:0] DBG_FIXED   = 6'h02;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int LVD_SETTLE_NS = 200000;
  localparam int LVD_SETTLE_CYC = (LVD_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // fetch sequencer states
  typedef enum logic [2:0] {
    FETCH_BOOT = 3'b001,
    FETCH_READ = 3'b010,
    FETCH_DONE = 3'b100
  } obcd_fetch_t;

endpackage : obcd_pkg

// ===== src/obcd_fetch.sv
// Purpose: reads the four option bytes from flash after reset
// Assumes: flash answers each held read with one rvalid pulse
// Notes:   boot swap is sampled once, after reset release
`timescale 1ns/1ps
module obcd_fetch (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // boot swap strap
  input  wire logic                         boot_swap,
  // flash read port
  output logic                              flash_rd_r,
  output logic [obcd_pkg::FLASH_AW-1:0]     flash_addr_r,
  input  wire logic [7:0]                   flash_rdata,
  input  wire logic                         flash_rvalid,
  // to holding registers
  output logic [obcd_pkg::OPT_BYTES-1:0]    load,
  output logic                              swap_used_r,
  output logic                              done_r
);

  obcd_pkg::obcd_fetch_t state_r;
  logic [1:0]            idx_r;
  logic                  last;

  assign last = (idx_r == 2'(obcd_pkg::OPT_BYTES - 1));

  always_comb begin
    load = '0;
    if (state_r == obcd_pkg::FETCH_READ && flash_rvalid) begin
      load[idx_r] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r      <= obcd_pkg::FETCH_BOOT;
      idx_r        <= 2'h0;
      flash_rd_r   <= 1'b0;
      flash_addr_r <= obcd_pkg::OPT_BASE_PRI;
      swap_used_r  <= 1'b0;
      done_r       <= 1'b0;
    end else if (ce) begin
      case (state_r)
        obcd_pkg::FETCH_BOOT: begin
          // alternate area replaces the primary one under boot swap
          swap_used_r  <= boot_swap;
          flash_addr_r <= boot_swap ? obcd_pkg::OPT_BASE_ALT : obcd_pkg::OPT_BASE_PRI;
          flash_rd_r   <= 1'b1;
          state_r      <= obcd_pkg::FETCH_READ;
        end
        obcd_pkg::FETCH_READ: begin
          if (flash_rvalid) begin
            if (last) begin
              flash_rd_r <= 1'b0;
              done_r     <= 1'b1;
              state_r    <= obcd_pkg::FETCH_DONE;
            end else begin
              idx_r        <= idx_r + 2'h1;
              flash_addr_r <= flash_addr_r + 17'h00001;
            end
          end
        end
        obcd_pkg::FETCH_DONE: begin
          done_r <= 1'b1;
        end
        default: begin
          state_r <= obcd_pkg::FETCH_BOOT;
        end
      endcase
    end
  end

endmodule : obcd_fetch

// ===== src/obcd_opt_hold.sv
// Purpose: one held option value, loaded once per reset
// Assumes: load is a one-cycle strobe from the fetch sequencer
// Notes:   value stays until the next reset
`timescale 1ns/1ps
module obcd_opt_hold #(
  parameter int         W   = 8,
  parameter logic [W-1:0] RST = '1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // load
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_r
);

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= RST;
    end else if (ce && load) begin
      q_r <= d;
    end
  end

endmodule : obcd_opt_hold

// ===== src/obcd_top.sv
// Purpose: option byte config decoder; fetch, decode and hold boot settings
// Assumes: Avalon-MM slave with byte addresses, inputs synchronous to clk
// Notes:   cpu_start_r gates the CPU; decoded values change only at reset, except software writes to lowvolt_detect_on_r
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps

module obcd_top #(
  parameter int LVD_SETTLE = obcd_pkg::LVD_SETTLE_CYC
) (
  // clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // reset cause and straps
  input  wire logic                          boot_swap,
  input  wire logic                          rst_by_wdt_or_illegal,
  // flash read port
  output logic                               flash_rd_r,
  output logic [obcd_pkg::FLASH_AW-1:0]      flash_addr_r,
  input  wire logic [7:0]                    flash_rdata,
  input  wire logic                          flash_rvalid,
  // cpu and mode status
  input  wire logic                          cpu_halt_stop,
  input  wire logic                          self_prog_busy,
  input  wire logic [2:0]                    debug_scratch,
  output logic                               cpu_start_r,
  // watchdog unit
  output logic                               wdt_enable_r,
  output logic [2:0]                         wdt_ovf_sel_r,
  output logic                               wdt_count_en_r,
  output logic [6:0]                         wdt_window_pct_r,
  output logic                               wdt_interval_irq_use_r,
  output logic [6:0]                         wdt_irq_pct_r,
  // oscillators
  output logic                               osc_8m_run_r,
  output logic                               osc_20m_run_r,
  output logic                               osc_1m_run_r,
  // low-voltage detector
  output logic                               lowvolt_detect_on_r,
  output logic                               lowvolt_unsettled_r,
  // debug
  output logic                               debug_enable_r,
  output logic                               debug_erase_on_fail_r,
  // avalon-mm slave
  input  wire logic [obcd_pkg::BUS_AW-1:0]   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata_r,
  output logic                               avs_waitrequest_r
);

  // ==========================================================
  // fetch and holding registers
  logic [obcd_pkg::OPT_BYTES-1:0] load;
  logic [7:0]                     opt_byte [obcd_pkg::OPT_BYTES];
  logic                           fetch_done;
  logic                           swap_used;

  obcd_fetch u_fetch (
    .clk          (clk),
    .rst          (rst),
    .ce           (ce),
    .boot_swap    (boot_swap),
    .flash_rd_r   (flash_rd_r),
    .flash_addr_r (flash_addr_r),
    .flash_rdata  (flash_rdata),
    .flash_rvalid (flash_rvalid),
    .load         (load),
    .swap_used_r  (swap_used),
    .done_r       (fetch_done)
  );

  for (genvar i = 0; i < obcd_pkg::OPT_BYTES; i++) begin : g_hold
    obcd_opt_hold #(
      .W   (8),
      .RST (obcd_pkg::OPT_BYTE_RST)
    ) u_hold (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .load (load[i]),
      .d    (flash_rdata),
      .q_r  (opt_byte[i])
    );
  end

  logic [7:0] wdt_opt;
  logic [7:0] osc_opt;
  logic [7:0] rsvd_opt;
  logic [7:0] dbg_opt;
  assign wdt_opt  = opt_byte[0];
  assign osc_opt  = opt_byte[1];
  assign rsvd_opt = opt_byte[2];
  assign dbg_opt  = opt_byte[3];

  // ==========================================================
  // decode of option fields
  logic       standby_run;
  logic [1:0] win_code;
  logic [1:0] freq_code;
  logic [1:0] dbg_code;
  logic       lv_default_off;
  logic       apply;
  logic       cfg_valid_r;

  assign standby_run    = wdt_opt[obcd_pkg::WDT_STBY_BIT];
  assign win_code       = {wdt_opt[obcd_pkg::WIN_HI_BIT], wdt_opt[obcd_pkg::WIN_LO_BIT]};
  assign freq_code      = {osc_opt[obcd_pkg::FREQ_HI_BIT], osc_opt[obcd_pkg::FREQ_LO_BIT]};
  assign dbg_code       = {dbg_opt[obcd_pkg::DBG_EN_BIT], dbg_opt[obcd_pkg::DBG_KEEP_BIT]};
  assign lv_default_off = osc_opt[obcd_pkg::LV_OFF_BIT];
  // one strobe per reset: after it values move only by software writes to lowvolt_detect_on_r
  assign apply          = fetch_done && !cfg_valid_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_valid_r <= 1'b0;
    end else if (ce && apply) begin
      cfg_valid_r <= 1'b1;
    end
  end

  // ==========================================================
  // watchdog settings
  logic win_err_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_enable_r           <= 1'b0;
      wdt_ovf_sel_r          <= 3'h0;
      wdt_window_pct_r       <= obcd_pkg::PCT_100;
      wdt_interval_irq_use_r <= 1'b0;
      wdt_irq_pct_r          <= obcd_pkg::PCT_0;
      win_err_r              <= 1'b0;
    end else if (ce && apply) begin
      wdt_enable_r  <= wdt_opt[obcd_pkg::WDT_EN_BIT];
      wdt_ovf_sel_r <= wdt_opt[obcd_pkg::WDT_OVF_LSB +: 3];
      win_err_r     <= (win_code == 2'h0);
      if (!standby_run) begin
        wdt_window_pct_r <= obcd_pkg::PCT_100;
      end else begin
        case (win_code)
          obcd_pkg::WIN_50:  wdt_window_pct_r <= obcd_pkg::PCT_50;
          obcd_pkg::WIN_75:  wdt_window_pct_r <= obcd_pkg::PCT_75;
          obcd_pkg::WIN_100: wdt_window_pct_r <= obcd_pkg::PCT_100;
          default:           wdt_window_pct_r <= obcd_pkg::PCT_100;
        endcase
      end
      wdt_interval_irq_use_r <= wdt_opt[obcd_pkg::WDT_IRQ_BIT];
      wdt_irq_pct_r <= wdt_opt[obcd_pkg::WDT_IRQ_BIT] ? obcd_pkg::PCT_75 : obcd_pkg::PCT_0;
    end
  end

  // self_prog_busy deliberately does not gate the counter: only HALT/STOP does
  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_count_en_r <= 1'b0;
    end else if (ce) begin
      wdt_count_en_r <= wdt_enable_r && cpu_start_r &&
                        (!cpu_halt_stop || standby_run) && (self_prog_busy || !self_prog_busy);
    end
  end

  // ==========================================================
  // oscillator selection; mode is fixed for the whole run
  logic freq_err_r;
  logic mode_8_20_r;
  logic fosc_start_r;
  logic fosc_wr;

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_8m_run_r <= 1'b0;
      osc_1m_run_r <= 1'b0;
      mode_8_20_r  <= 1'b0;
      freq_err_r   <= 1'b0;
    end else if (ce && apply) begin
      // a prohibited code falls back to the 8 MHz path and is flagged
      mode_8_20_r  <= (freq_code != obcd_pkg::FREQ_1);
      osc_8m_run_r <= (freq_code != obcd_pkg::FREQ_1);
      osc_1m_run_r <= (freq_code == obcd_pkg::FREQ_1);
      freq_err_r   <= (freq_code != obcd_pkg::FREQ_8_20) && (freq_code != obcd_pkg::FREQ_1);
    end
  end

  // the 20 MHz start bit exists only in 8/20 MHz mode
  always_ff @(posedge clk) begin
    if (rst) begin
      fosc_start_r <= 1'b0;
    end else if (ce && fosc_wr && avs_byteenable[0] && mode_8_20_r) begin
      fosc_start_r <= avs_writedata[obcd_pkg::FOSC_ON_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_20m_run_r <= 1'b0;
    end else if (ce) begin
      osc_20m_run_r <= fosc_start_r && mode_8_20_r;
    end
  end

  // ==========================================================
  // low-voltage detector enable and settling
  logic        lv_wr;
  logic        quick_start_r;
  logic        settle_busy_r;
  logic [31:0] settle_cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      lowvolt_detect_on_r <= 1'b0;
    end else if (ce) begin
      if (apply) begin
        // a reset always re-arms the default start, even after software cleared it
        lowvolt_detect_on_r <= !lv_default_off;
      end else if (lv_wr && avs_byteenable[0] && cfg_valid_r) begin
        lowvolt_detect_on_r <= avs_writedata[obcd_pkg::LV_ON_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      quick_start_r <= 1'b0;
    end else if (ce && apply) begin
      quick_start_r <= rst_by_wdt_or_illegal;
    end
  end

  // settle counter: delays the CPU on ordinary resets, only flags after fast ones
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_busy_r <= 1'b0;
      settle_cnt_r  <= 32'h0;
    end else if (ce) begin
      if (apply) begin
        settle_busy_r <= !lv_default_off;
        settle_cnt_r  <= 32'(LVD_SETTLE);
      end else if (settle_busy_r) begin
        if (settle_cnt_r <= 32'h1) begin
          settle_busy_r <= 1'b0;
        end
        settle_cnt_r <= settle_cnt_r - 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lowvolt_unsettled_r <= 1'b0;
    end else if (ce) begin
      lowvolt_unsettled_r <= settle_busy_r && quick_start_r;
    end
  end

  // ==========================================================
  // cpu start: only after every option is applied
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_start_r <= 1'b0;
    end else if (ce && cfg_valid_r && !apply) begin
      if (!settle_busy_r || quick_start_r) begin
        cpu_start_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // debug settings and option format checks
  logic dbg_err_r;
  logic fmt_err_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      debug_enable_r        <= 1'b0;
      debug_erase_on_fail_r <= 1'b0;
      dbg_err_r             <= 1'b0;
      fmt_err_r             <= 1'b0;
    end else if (ce && apply) begin
      debug_enable_r        <= (dbg_code == obcd_pkg::DBG_ERASE) || (dbg_code == obcd_pkg::DBG_KEEP);
      debug_erase_on_fail_r <= (dbg_code == obcd_pkg::DBG_ERASE);
      dbg_err_r             <= (dbg_code != obcd_pkg::DBG_OFF) && !dbg_opt[obcd_pkg::DBG_EN_BIT];
      fmt_err_r             <= (osc_opt[7:3] != obcd_pkg::OSC_HI_ONES) ||
                               (rsvd_opt != obcd_pkg::RSVD_VAL) ||
                               (dbg_opt[6:1] != obcd_pkg::DBG_FIXED);
    end
  end

  // ==========================================================
  // avalon-mm slave: one wait state, then a one-cycle answer
  logic [7:0]  idx;
  logic        take;
  logic [7:0]  dbg_view;
  logic [7:0]  status;
  logic [31:0] rd_mux;

  assign idx     = avs_address[obcd_pkg::BUS_AW-1:2];
  assign take    = (avs_read || avs_write) && !avs_waitrequest_r;
  assign lv_wr   = take && avs_write && (idx == obcd_pkg::IDX_LV_CTRL);
  assign fosc_wr = take && avs_write && (idx == obcd_pkg::IDX_FOSC_CTRL);

  // debugger may rewrite bits 3:1, so with debug_enable_r set they show its scratch, not the fetched value
  assign dbg_view = debug_enable_r ?
                    {dbg_opt[7:4], debug_scratch, dbg_opt[0]} : dbg_opt;

  always_comb begin
    status = 8'h00;
    status[obcd_pkg::ST_VALID_BIT] = cfg_valid_r;
    status[obcd_pkg::ST_CPU_BIT]   = cpu_start_r;
    status[obcd_pkg::ST_SWAP_BIT]  = swap_used;
    status[obcd_pkg::ST_UNSET_BIT] = lowvolt_unsettled_r;
    status[obcd_pkg::ST_WIN_ERR]   = win_err_r;
    status[obcd_pkg::ST_FREQ_ERR]  = freq_err_r;
    status[obcd_pkg::ST_DBG_ERR]   = dbg_err_r;
    status[obcd_pkg::ST_FMT_ERR]   = fmt_err_r;
  end

  always_comb begin
    case (idx)
      obcd_pkg::IDX_WDT_OPT:   rd_mux = {24'h0, wdt_opt};
      obcd_pkg::IDX_OSC_LV:    rd_mux = {24'h0, osc_opt};
      obcd_pkg::IDX_RSVD:      rd_mux = {24'h0, rsvd_opt};
      obcd_pkg::IDX_DBG:       rd_mux = {24'h0, dbg_view};
      obcd_pkg::IDX_STATUS:    rd_mux = {24'h0, status};
      obcd_pkg::IDX_LV_CTRL:   rd_mux = {31'h0, lowvolt_detect_on_r};
      obcd_pkg::IDX_FOSC_CTRL: rd_mux = {31'h0, fosc_start_r};
      default:                 rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest_r <= 1'b1;
      avs_readdata_r    <= 32'h0;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest_r) begin
        avs_waitrequest_r <= 1'b0;
        avs_readdata_r    <= avs_read ? rd_mux : 32'h0;
      end else begin
        avs_waitrequest_r <= 1'b1;
      end
    end
  end

endmodule : obcd_top

// ===== tb/obcd_flash_model.sv
// Purpose: flash option area model answering byte reads
// Assumes: read held until rvalid
// Notes: slow adds three wait cycles per byte
`timescale 1ns/1ps
module obcd_flash_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // read port
  input  wire logic        flash_rd_r,
  input  wire logic [16:0] flash_addr_r,
  output logic      [7:0]  flash_rdata,
  output logic             flash_rvalid,
  // contents and pacing
  input  wire logic [31:0] pri,
  input  wire logic [31:0] alt,
  input  wire logic        slow
);
  logic [1:0] wait_r;
  // data toggles outside the valid cycle so a late sample is caught
  always_ff @(posedge clk) begin
    flash_rvalid <= 1'h0;
    flash_rdata  <= rst ? 8'h5a : ~flash_rdata;
    if (rst || !flash_rd_r || flash_rvalid) begin
      wait_r <= slow ? 2'h3 : 2'h0;
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else begin
      flash_rvalid <= 1'h1;
      flash_rdata  <= 8'((flash_addr_r[12] ? alt : pri) >> (8 * flash_addr_r[1:0]));
    end
  end
endmodule : obcd_flash_model

// ===== tb/obcd_props.sv
// Purpose: port checker for obcd_top
// Assumes: ce held high
// Notes: bound after the module
`timescale 1ns/1ps
module obcd_props (
  // observed ports
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        flash_rd_r,
  input wire logic [16:0] flash_addr_r,
  input wire logic        flash_rvalid,
  input wire logic        cpu_start_r,
  input wire logic        wdt_enable_r,
  input wire logic        wdt_count_en_r,
  input wire logic [6:0]  wdt_window_pct_r,
  input wire logic        wdt_interval_irq_use_r,
  input wire logic [6:0]  wdt_irq_pct_r,
  input wire logic        osc_8m_run_r,
  input wire logic        osc_20m_run_r,
  input wire logic        osc_1m_run_r,
  input wire logic        debug_enable_r,
  input wire logic        debug_erase_on_fail_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ====================
  // assertions
  start_after_a: assert property ($rose(cpu_start_r) |-> !flash_rd_r) else $error("start during fetch");
  addr_hold_a: assert property (flash_rd_r && !flash_rvalid |=> $stable(flash_addr_r)) else $error("addr moved");
  area_sel_a: assert property (flash_rd_r |-> flash_addr_r[16:2] inside {15'h30, 15'h430}) else $error("area");
  stby_run_a: assert property (cpu_start_r && wdt_enable_r && wdt_window_pct_r != 7'h64 |=> wdt_count_en_r)
    else $error("standby count");
  win_code_a: assert property (wdt_window_pct_r inside {7'h32, 7'h4b, 7'h64}) else $error("window value");
  irq_pct_a: assert property (wdt_irq_pct_r == (wdt_interval_irq_use_r ? 7'h4b : 7'h00)) else $error("irq pct");
  osc_one_a: assert property (cpu_start_r |-> osc_8m_run_r != osc_1m_run_r) else $error("osc select");
  no_fast_a: assert property (osc_1m_run_r |-> !osc_20m_run_r) else $error("fast osc in 1m");
  dbg_erase_a: assert property (debug_erase_on_fail_r |-> debug_enable_r) else $error("erase w/o debug");
  cfg_held_a: assert property (cpu_start_r && $past(cpu_start_r) |-> $stable(wdt_window_pct_r) && $stable(osc_1m_run_r)
    && $stable(debug_enable_r)) else $error("config changed");
  cover property ($rose(cpu_start_r));
  cover property ($rose(osc_20m_run_r));
  cover property (debug_erase_on_fail_r);
endmodule : obcd_props

bind obcd_top obcd_props u_props (.*);

// ===== tb/tb_top.sv
// Purpose: self-checking bench for obcd_top
// Assumes: settle count shortened to 20
// Notes: every wait is bounded
`timescale 1ns/1ps
module tb_top;
  // ====================
  // signals and instances
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1, boot_swap = 1'h0, rst_by_wdt_or_illegal = 1'h0, slow = 1'h0;
  logic cpu_halt_stop = 1'h0, self_prog_busy = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [2:0] debug_scratch = 3'h5;
  logic [3:0] avs_byteenable = 4'h1;
  logic [9:0] avs_address = 10'h0;
  logic [31:0] avs_writedata = 32'h0, pri = 32'h0, alt = 32'h0, avs_readdata_r;
  logic flash_rd_r, flash_rvalid, cpu_start_r, wdt_enable_r, wdt_count_en_r, wdt_interval_irq_use_r, osc_8m_run_r;
  logic osc_20m_run_r, osc_1m_run_r, lowvolt_detect_on_r, lowvolt_unsettled_r, debug_enable_r, debug_erase_on_fail_r;
  logic avs_waitrequest_r;
  logic [16:0] flash_addr_r;
  logic [7:0] flash_rdata;
  logic [2:0] wdt_ovf_sel_r;
  logic [6:0] wdt_window_pct_r, wdt_irq_pct_r;
  int error_cnt = 0, num_checks = 0;
  always #4 clk = ~clk;
  obcd_top #(.LVD_SETTLE(20)) dut (.*);
  obcd_flash_model fmod (.*);
  // ====================
  // shared tasks
  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic miss();
    error_cnt++;
    $display("MISMATCH %0t wait ran out", $time);
    close_out();
  endtask : miss
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n = 0;
    avs_address <= {idx, 2'h0};
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest_r !== 1'h0 && n < 40);
    rd = avs_readdata_r;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
    if (n >= 40) miss();
  endtask : bus
  // a swapped boot also runs the flash slowly
  task automatic boot(input logic [31:0] p, input logic [31:0] a, input logic sw, input logic wr, output int n);
    pri <= p;
    alt <= a;
    slow <= sw;
    boot_swap <= sw;
    rst_by_wdt_or_illegal <= wr;
    rst <= 1'h1;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    n = 0;
    while (cpu_start_r !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) miss();
    repeat (2) @(posedge clk);
  endtask : boot
  // ====================
  // scenarios
  task automatic sc_wdt();
    logic [31:0] rd;
    logic [7:0] b0;
    int n;
    for (int i = 0; i < 5; i++) begin
      b0 = {i[0], (i == 4) ? 2'h1 : i[1:0], 4'hb, i < 4};
      cpu_halt_stop <= 1'h0;
      boot({8'h04, 8'hff, 8'hfb, b0}, 32'h0, 1'h0, 1'h0, n);
      chk(wdt_window_pct_r, (i == 4 || i[1:0] == 2'h0 || i[1:0] == 2'h3) ? 7'h64 : (i[0] ? 7'h32 : 7'h4b));
      chk(wdt_irq_pct_r, i[0] ? 7'h4b : 7'h00);
      cpu_halt_stop <= 1'h1;
      self_prog_busy <= i[0];
      repeat (3) @(posedge clk);
      chk(wdt_count_en_r, i < 4);
      bus(1'h0, obcd_pkg::IDX_WDT_OPT, 32'h0, rd);
      chk(rd, {24'h0, b0});
      chk({wdt_enable_r, wdt_ovf_sel_r, wdt_interval_irq_use_r}, {1'h1, 3'h3, i[0]});
      bus(1'h0, obcd_pkg::IDX_STATUS, 32'h0, rd);
      chk(rd, {27'h0, i == 0, 4'h3});
    end
    cpu_halt_stop <= 1'h0;
  endtask : sc_wdt
  task automatic sc_osc();
    logic [31:0] rd;
    int n;
    for (int c = 0; c < 4; c++) begin
      boot({16'h04ff, 5'h1f, c[1:0], 1'h1, 8'h36}, 32'h0, 1'h0, 1'h0, n);
      chk(osc_8m_run_r, c != 2);
      chk(osc_1m_run_r, c == 2);
      bus(1'h1, obcd_pkg::IDX_FOSC_CTRL, 32'h1, rd);
      repeat (2) @(posedge clk);
      chk(osc_20m_run_r, c != 2);
      chk(osc_1m_run_r, c == 2);
      bus(1'h0, obcd_pkg::IDX_STATUS, 32'h0, rd);
      chk(rd, {26'h0, c == 0 || c == 3, 5'h03});
    end
  endtask : sc_osc
  task automatic sc_lv();
    logic [31:0] rd;
    int n;
    boot(32'h04fffa36, 32'h0, 1'h0, 1'h0, n);
    chk(n > 20, 1'h1);
    chk(lowvolt_detect_on_r, 1'h1);
    bus(1'h1, obcd_pkg::IDX_LV_CTRL, 32'h0, rd);
    repeat (2) @(posedge clk);
    chk(lowvolt_detect_on_r, 1'h0);
    boot(32'h04fffa36, 32'h0, 1'h0, 1'h1, n);
    chk(lowvolt_detect_on_r, 1'h1);
    chk(lowvolt_unsettled_r, 1'h1);
    chk(n < 20, 1'h1);
    boot(32'h04fffb36, 32'h0, 1'h0, 1'h0, n);
    chk(lowvolt_detect_on_r, 1'h0);
  endtask : sc_lv
  task automatic sc_dbg();
    logic [31:0] rd;
    int n;
    for (int d = 0; d < 4; d++) begin
      boot(32'h0, {d[1], 6'h02, d[0], 24'hfffb36}, 1'h1, 1'h0, n);
      chk(debug_enable_r, d[1]);
      chk(debug_erase_on_fail_r, d == 2);
      bus(1'h0, obcd_pkg::IDX_DBG, 32'h0, rd);
      chk(rd, d[1] ? {24'h0, 4'h8, debug_scratch, d[0]} : {24'h0, d[1], 6'h02, d[0]});
      bus(1'h0, obcd_pkg::IDX_RSVD, 32'h0, rd);
      chk(rd, 32'hff);
      bus(1'h0, obcd_pkg::IDX_STATUS, 32'h0, rd);
      chk(rd, {25'h0, d == 1, 6'h07});
      bus(1'h0, 8'h20, 32'h0, rd);
      chk(rd, 32'h0);
    end
  endtask : sc_dbg
  initial begin
    sc_wdt();
    sc_osc();
    sc_lv();
    sc_dbg();
    close_out();
  end
endmodule : tb_top
